// file: common/burst_policy_pkg.sv
// Shared types and constants for the bus-master burst policy block.
// Assumes a 32-bit PCI-style initiator sequencer consumes its decisions.
package burst_policy_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Register offsets (word addresses on the plain register port)
  localparam logic [3:0] ADDR_PCI_CMD = 4'h0;
  localparam logic [3:0] ADDR_PCI_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CFG = 4'h2;
  localparam logic [3:0] ADDR_CACHE_LINE = 4'h3;
  localparam logic [3:0] ADDR_POWER = 4'h4;
  localparam logic [3:0] ADDR_TX_MAX = 4'h5;
  // Command register field positions
  localparam int unsigned CMD_MWI_EN_BIT = 4;
  localparam int unsigned CMD_PERR_RESP_BIT = 6;
  // Status register field positions (write one to clear)
  localparam int unsigned STS_DATA_PAR_BIT = 8;
  localparam int unsigned STS_TGT_ABORT_BIT = 12;
  localparam int unsigned STS_DET_PAR_BIT = 15;
  // Configure byte 3 fields, placed at bits [31:24] of the config word
  localparam int unsigned CFG_MWI_EN_BIT = 24;
  localparam int unsigned CFG_READ_ALIGN_BIT = 26;
  localparam int unsigned CFG_TERM_ON_LINE_BIT = 27;
  // Reset values
  localparam logic [15:0] PCI_CMD_RST = 16'h0000;
  localparam logic [15:0] PCI_STATUS_RST = 16'h0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [7:0] CACHE_LINE_RST = 8'h00;
  localparam logic [1:0] POWER_RST = 2'h0;
  localparam logic [7:0] TX_MAX_RST = 8'h00;
  // Accepted cache line sizes in dwords, and the D1 power state code
  localparam logic [7:0] CLS_8 = 8'h08;
  localparam logic [7:0] CLS_16 = 8'h10;
  localparam logic [1:0] PWR_D1 = 2'h1;
  // Bus commands on C/BE# during the address phase, and byte enables for data phases
  localparam logic [3:0] PCI_CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] PCI_CMD_MEM_WRITE_INV = 4'hf;
  localparam logic [3:0] BE_ALL_ACTIVE_N = 4'h0;

  typedef enum logic [1:0] {
    TERM_NORMAL = 2'b00,
    TERM_RETRY = 2'b01,
    TERM_DISCONNECT = 2'b10,
    TERM_ABORT = 2'b11
  } term_t;

  // Request for a receive write burst
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] fifo_dwords;
    logic [15:0] space_dwords;
    logic ctrl_struct;
  } wr_req_t;

  // State of an ongoing burst as seen by the sequencer
  typedef struct packed {
    logic data_phase;
    logic [31:0] addr;
    logic is_read;
    logic par_err;
  } phase_t;
endpackage : burst_policy_pkg

// file: src/burst_policy.sv
// Bus-master burst policy: command choice, line alignment, initiator parity.
// Assumes an external PCI sequencer carries out start/stop/phase decisions.
// Contract
// [R01] MWI bursts carry at least one whole line
// [R02] All byte enables active during MWI data
// [R03] MWI crosses line only for whole next line
// [R04] MWI only with line size 8 or 16
// [R05] MWI only at line-aligned start address
// [R06] MWI only with a line in receive FIFO
// [R07] MWI only with a line of buffer space
// [R08] MWI needs both command and configure enables
// [R09] Otherwise plain memory write is issued
// [R10] Failing condition ends MWI at line end
// [R11] Terminate-on-line bit ends plain write at boundary
// [R12] Read align only with its configure bit
// [R13] Nearly full transmit FIFO ends read at line
// [R14] With byte limit, switch channels at lines
// [R15] Software enables align only for 8/16 lines
// [R16] Aligned mode fetches structures from first dword
// [R17] Initiator data parity error raises PERR, bit 8
// [R18] Read parity error also sets bit 15
// [R19] No bus mastering while in D1
// [R20] Only receive data may use MWI
// [R21] Target abort sets bit 12, no retry
// [R22] Plain write 0111, invalidate write 1111
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module burst_policy
  import burst_policy_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic wr_start_in,
  input wire burst_policy_pkg::wr_req_t wr_req_in,
  input wire logic rd_start_in,
  input wire logic [31:0] rd_addr_in,
  input wire logic rd_ctrl_struct_in,
  input wire burst_policy_pkg::phase_t phase_in,
  input wire logic [15:0] fifo_dwords_in,
  input wire logic [15:0] space_dwords_in,
  input wire logic tx_fifo_nearly_full_in,
  input wire logic other_dma_pending_in,
  input wire logic term_valid_in,
  input wire burst_policy_pkg::term_t term_in,
  output logic start_ok_out,
  output logic [3:0] cmd_out,
  output logic [3:0] be_n_out,
  output logic [31:0] start_addr_out,
  output logic burst_stop_out,
  output logic retry_out,
  output logic perr_n_out
);
  import burst_policy_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10
  } state_t;

  logic [15:0] pci_cmd_r, pci_cmd_nxt;
  logic [15:0] pci_status_r, pci_status_nxt;
  logic [31:0] cfg_r, cfg_nxt;
  logic [7:0] cache_line_r, cache_line_nxt;
  logic [1:0] power_r, power_nxt;
  logic [7:0] tx_max_r, tx_max_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  state_t state_r, state_nxt;
  logic mwi_r, mwi_nxt;
  logic [3:0] cmd_r, cmd_nxt;
  logic [31:0] start_addr_r, start_addr_nxt;
  logic [7:0] tx_count_r, tx_count_nxt;
  logic retry_r, retry_nxt;
  logic perr_r, perr_nxt;

  logic cls_ok, line_mask_ok, at_line_end, mwi_cond_now, read_align;
  logic [5:0] line_bytes;

  always_comb begin
    cls_ok = (cache_line_r == CLS_8) || (cache_line_r == CLS_16); // R04
    line_bytes = (cache_line_r == CLS_16) ? 6'h3f : 6'h1f;
    read_align = cfg_r[CFG_READ_ALIGN_BIT] && cls_ok; // R12 R15
    // Last dword of a line is in the current data phase
    at_line_end = ((phase_in.addr[5:0] & line_bytes) == (line_bytes & 6'h3c));
    line_mask_ok = ((wr_req_in.addr[5:0] & line_bytes) == 6'h00); // R05
    // Running check for continuing an invalidate burst into the next line
    mwi_cond_now = cls_ok && pci_cmd_r[CMD_MWI_EN_BIT] && cfg_r[CFG_MWI_EN_BIT]
      && (fifo_dwords_in >= {8'h00, cache_line_r}) // R06
      && (space_dwords_in >= {8'h00, cache_line_r}); // R07
  end

  // Register file and status flags
  always_comb begin
    pci_cmd_nxt = pci_cmd_r;
    pci_status_nxt = pci_status_r;
    cfg_nxt = cfg_r;
    cache_line_nxt = cache_line_r;
    power_nxt = power_r;
    tx_max_nxt = tx_max_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_PCI_CMD: pci_cmd_nxt = reg_wdata_in[15:0];
        ADDR_PCI_STATUS: pci_status_nxt = pci_status_r & ~reg_wdata_in[15:0];
        ADDR_CFG: cfg_nxt = reg_wdata_in;
        ADDR_CACHE_LINE: cache_line_nxt = reg_wdata_in[7:0];
        ADDR_POWER: power_nxt = reg_wdata_in[1:0];
        ADDR_TX_MAX: tx_max_nxt = reg_wdata_in[7:0];
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_PCI_CMD: rdata_nxt = {16'h0000, pci_cmd_r};
        ADDR_PCI_STATUS: rdata_nxt = {16'h0000, pci_status_r};
        ADDR_CFG: rdata_nxt = cfg_r;
        ADDR_CACHE_LINE: rdata_nxt = {24'h000000, cache_line_r};
        ADDR_POWER: rdata_nxt = {30'h0, power_r};
        ADDR_TX_MAX: rdata_nxt = {24'h000000, tx_max_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    // Hardware set wins over a same-cycle clear
    if (phase_in.data_phase && phase_in.par_err && state_r != ST_IDLE
        && pci_cmd_r[CMD_PERR_RESP_BIT]) begin
      pci_status_nxt[STS_DATA_PAR_BIT] = 1'b1; // R17
      if (phase_in.is_read) begin
        pci_status_nxt[STS_DET_PAR_BIT] = 1'b1; // R18
      end
    end
    if (term_valid_in && term_in == TERM_ABORT && state_r != ST_IDLE) begin
      pci_status_nxt[STS_TGT_ABORT_BIT] = 1'b1; // R21
    end
  end

  // Burst decision state
  always_comb begin
    state_nxt = state_r;
    mwi_nxt = mwi_r;
    cmd_nxt = cmd_r;
    start_addr_nxt = start_addr_r;
    tx_count_nxt = tx_count_r;
    retry_nxt = 1'b0;
    perr_nxt = 1'b0;
    if (phase_in.data_phase && phase_in.par_err && state_r != ST_IDLE) begin
      perr_nxt = pci_cmd_r[CMD_PERR_RESP_BIT]; // R17
    end
    case (state_r)
      ST_IDLE: begin
        if (power_r != PWR_D1) begin // R19
          if (wr_start_in) begin
            state_nxt = ST_WRITE;
            start_addr_nxt = wr_req_in.addr;
            // Receive data only; structure writes stay plain
            mwi_nxt = !wr_req_in.ctrl_struct && cls_ok && line_mask_ok // R20 R04 R05
              && (wr_req_in.fifo_dwords >= {8'h00, cache_line_r}) // R06
              && (wr_req_in.space_dwords >= {8'h00, cache_line_r}) // R07
              && pci_cmd_r[CMD_MWI_EN_BIT] && cfg_r[CFG_MWI_EN_BIT]; // R08
            cmd_nxt = mwi_nxt ? PCI_CMD_MEM_WRITE_INV : PCI_CMD_MEM_WRITE; // R09 R22
          end else if (rd_start_in) begin
            state_nxt = ST_READ;
            tx_count_nxt = 8'h00;
            mwi_nxt = 1'b0;
            // In aligned read mode, structures fetched from the line's first dword
            start_addr_nxt = (read_align && rd_ctrl_struct_in) // R16
              ? {rd_addr_in[31:6], rd_addr_in[5:0] & ~line_bytes} : rd_addr_in;
          end
        end
      end
      ST_WRITE, ST_READ: begin
        if (phase_in.data_phase && state_r == ST_READ) begin
          tx_count_nxt = tx_count_r + 8'h01;
        end
        if (term_valid_in) begin
          state_nxt = ST_IDLE;
          retry_nxt = (term_in == TERM_RETRY) || (term_in == TERM_DISCONNECT); // R21
        end else if (burst_stop_out) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Stop request at a line end only; reads are stopped only in aligned read mode
  always_comb begin
    burst_stop_out = 1'b0;
    if (state_r == ST_WRITE && phase_in.data_phase && at_line_end) begin
      if (mwi_r) begin
        burst_stop_out = !mwi_cond_now; // R10 R03 R01
      end else begin
        burst_stop_out = cfg_r[CFG_TERM_ON_LINE_BIT]; // R11
      end
    end else if (state_r == ST_READ && phase_in.data_phase && read_align && at_line_end) begin
      burst_stop_out = tx_fifo_nearly_full_in // R13
        || (tx_max_r != 8'h00 && tx_count_r >= tx_max_r && other_dma_pending_in); // R14
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pci_cmd_r <= PCI_CMD_RST;
      pci_status_r <= PCI_STATUS_RST;
      cfg_r <= CFG_RST;
      cache_line_r <= CACHE_LINE_RST;
      power_r <= POWER_RST;
      tx_max_r <= TX_MAX_RST;
      rdata_r <= 32'h0000_0000;
      state_r <= ST_IDLE;
      mwi_r <= 1'b0;
      cmd_r <= PCI_CMD_MEM_WRITE;
      start_addr_r <= 32'h0000_0000;
      tx_count_r <= 8'h00;
      retry_r <= 1'b0;
      perr_r <= 1'b0;
    end else begin
      pci_cmd_r <= pci_cmd_nxt;
      pci_status_r <= pci_status_nxt;
      cfg_r <= cfg_nxt;
      cache_line_r <= cache_line_nxt;
      power_r <= power_nxt;
      tx_max_r <= tx_max_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      mwi_r <= mwi_nxt;
      cmd_r <= cmd_nxt;
      start_addr_r <= start_addr_nxt;
      tx_count_r <= tx_count_nxt;
      retry_r <= retry_nxt;
      perr_r <= perr_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign start_ok_out = (state_r == ST_IDLE) && (power_r != PWR_D1); // R19
  assign cmd_out = cmd_r;
  assign be_n_out = BE_ALL_ACTIVE_N; // R02
  assign start_addr_out = start_addr_r;
  assign retry_out = retry_r;
  assign perr_n_out = !perr_r;
endmodule : burst_policy
`default_nettype wire

// file: test/burst_policy_asserts.sv
// Port checker for the burst policy block.
// Assumes a bind from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module burst_policy_asserts
  import burst_policy_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic wr_start_in,
  input wire burst_policy_pkg::wr_req_t wr_req_in,
  input wire burst_policy_pkg::phase_t phase_in,
  input wire logic term_valid_in,
  input wire burst_policy_pkg::term_t term_in,
  input wire logic start_ok_out,
  input wire logic [3:0] cmd_out,
  input wire logic [3:0] be_n_out,
  input wire logic retry_out,
  input wire logic perr_n_out
);
  logic [15:0] cmd_r;
  logic [31:0] cfg_r;
  logic [7:0] cls_r;
  logic [1:0] pwr_r;
  logic go;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Shadow of written registers
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cmd_r <= PCI_CMD_RST;
      cfg_r <= CFG_RST;
      cls_r <= CACHE_LINE_RST;
      pwr_r <= POWER_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_PCI_CMD) cmd_r <= reg_wdata_in[15:0];
      if (reg_addr_in == ADDR_CFG) cfg_r <= reg_wdata_in;
      if (reg_addr_in == ADDR_CACHE_LINE) cls_r <= reg_wdata_in[7:0];
      if (reg_addr_in == ADDR_POWER) pwr_r <= reg_wdata_in[1:0];
    end
  end
  assign go = wr_start_in && start_ok_out;
  property p_be; be_n_out == BE_ALL_ACTIVE_N; endproperty
  a_be: assert property (p_be) else $error("byte enables not all active");
  property p_code; cmd_out == PCI_CMD_MEM_WRITE || cmd_out == PCI_CMD_MEM_WRITE_INV; endproperty
  a_code: assert property (p_code) else $error("bad write command");
  property p_en; go && !(cmd_r[CMD_MWI_EN_BIT] && cfg_r[CFG_MWI_EN_BIT]) |=> cmd_out == 4'h7; endproperty
  a_en: assert property (p_en) else $error("invalidate while disabled");
  property p_cls; go && cls_r != CLS_8 && cls_r != CLS_16 |=> cmd_out == 4'h7; endproperty
  a_cls: assert property (p_cls) else $error("invalidate with bad line size");
  property p_room; go && (wr_req_in.fifo_dwords < {8'h00, cls_r}
    || wr_req_in.space_dwords < {8'h00, cls_r}) |=> cmd_out == 4'h7; endproperty
  a_room: assert property (p_room) else $error("invalidate without a line");
  property p_ctrl; go && wr_req_in.ctrl_struct |=> cmd_out == 4'h7; endproperty
  a_ctrl: assert property (p_ctrl) else $error("invalidate for structure");
  property p_d1; pwr_r == PWR_D1 |-> !start_ok_out; endproperty
  a_d1: assert property (p_d1) else $error("start allowed in low power");
  property p_perr; phase_in.data_phase && phase_in.par_err && cmd_r[CMD_PERR_RESP_BIT]
    |=> !perr_n_out; endproperty
  a_perr: assert property (p_perr) else $error("parity error not flagged");
  property p_abort; term_valid_in && term_in == TERM_ABORT |=> !retry_out [*2]; endproperty
  a_abort: assert property (p_abort) else $error("retry after abort");
  property p_retry; term_valid_in && (term_in == TERM_RETRY || term_in == TERM_DISCONNECT)
    |=> retry_out; endproperty
  a_retry: assert property (p_retry) else $error("no retry");
endmodule : burst_policy_asserts
`default_nettype wire

// file: test/mem_target_model.sv
// Memory target model: data phases and target terminations.
// Assumes go_in pulses the cycle after the block takes a start.
`timescale 1ns/1ps
`default_nettype none
module mem_target_model
  import burst_policy_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire logic rd_in,
  input wire logic [31:0] a_in,
  input wire logic [7:0] n_in,
  input wire logic [7:0] err_in,
  input wire burst_policy_pkg::term_t tc_in,
  input wire logic stop_in,
  output burst_policy_pkg::phase_t ph_out,
  output logic tv_out,
  output burst_policy_pkg::term_t tc_out,
  output logic [7:0] cnt_out
);
  always_ff @(posedge clk_in) begin
    tv_out <= 1'b0;
    if (!rst_n_in) begin
      ph_out <= '0;
      cnt_out <= 8'h00;
      tc_out <= TERM_NORMAL;
    end else if (go_in) begin
      cnt_out <= 8'h00;
      ph_out <= '{1'b1, a_in, rd_in, err_in == 8'h00};
    end else if (ph_out.data_phase) begin
      cnt_out <= cnt_out + 8'h01;
      ph_out.addr <= ph_out.addr + 32'h4;
      ph_out.par_err <= err_in == cnt_out + 8'h01;
      // Stop request or last phase ends the burst
      if (stop_in || cnt_out + 8'h01 == n_in) begin
        ph_out.data_phase <= 1'b0;
        ph_out.par_err <= 1'b0;
        tv_out <= !stop_in;
        tc_out <= tc_in;
      end
    end else begin
      ph_out.addr <= ~ph_out.addr;
    end
  end
endmodule : mem_target_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the burst policy block.
// Assumes the checker and the target model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import burst_policy_pkg::*;
  logic sys_clk_in = 1'b0, reset_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic wr_start_in = 1'b0, rd_start_in = 1'b0, rd_ctrl_struct_in = 1'b0, go = 1'b0;
  logic tx_fifo_nearly_full_in = 1'b0, other_dma_pending_in = 1'b0, rd = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, rd_addr_in = 32'h0, pa = 32'h0;
  logic [15:0] fifo_dwords_in = 16'h0, space_dwords_in = 16'h0;
  logic [7:0] pn = 8'h0, pe = 8'hff, cnt;
  wr_req_t wr_req_in = '0;
  term_t pt = TERM_NORMAL, term_in;
  phase_t phase_in;
  logic [31:0] reg_rdata_out, start_addr_out;
  logic [3:0] cmd_out, be_n_out;
  logic start_ok_out, burst_stop_out, retry_out, perr_n_out, term_valid_in;
  int failures = 0, n_compared = 0;
  burst_policy burst_policy_i (.*);
  mem_target_model mem_target_model_i (.clk_in(sys_clk_in), .rst_n_in(reset_n_in),
    .go_in(go), .rd_in(rd), .a_in(pa), .n_in(pn), .err_in(pe), .tc_in(pt),
    .stop_in(burst_stop_out), .ph_out(phase_in), .tv_out(term_valid_in),
    .tc_out(term_in), .cnt_out(cnt));
  always #2 sys_clk_in = ~sys_clk_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    {reg_addr_in, reg_rd_in} <= {a, 1'b1};
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask : rdc
  task automatic burst(input logic r, input logic [31:0] a, input logic [7:0] n, e,
      input term_t t);
    int k;
    @(posedge sys_clk_in);
    {wr_start_in, rd_start_in, rd_addr_in} <= {!r, r, a};
    wr_req_in.addr <= a;
    @(posedge sys_clk_in);
    {wr_start_in, rd_start_in} <= 2'b00;
    {go, rd, pa, pn, pe, pt} <= {1'b1, r, a, n, e, t};
    @(posedge sys_clk_in);
    go <= 1'b0;
    for (k = 0; k < 100; k++) begin
      @(posedge sys_clk_in);
      #1;
      if (!phase_in.data_phase && start_ok_out) break;
    end
    if (k == 100) begin
      failures++;
      stop_test();
    end
  endtask : burst
  task automatic wcase(input logic [7:0] c, input logic [31:0] a, input logic [15:0] f, s,
      input logic ct, input logic [3:0] exp);
    wr(ADDR_CACHE_LINE, {24'h0, c});
    {wr_req_in.fifo_dwords, wr_req_in.space_dwords, wr_req_in.ctrl_struct} <= {f, s, ct};
    {fifo_dwords_in, space_dwords_in} <= {f, s};
    burst(1'b0, a, 8'h08, 8'hff, TERM_NORMAL);
    chk({28'h0, cmd_out}, {28'h0, exp});
  endtask : wcase
  initial begin
    repeat (5) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(i[3:0], 32'h0);
    chk({28'h0, cmd_out}, 32'h7);
    wr(ADDR_PCI_CMD, 32'h10);
    wr(ADDR_CFG, 32'h0100_0000);
    wcase(CLS_8, 32'h100, 16'h10, 16'h10, 1'b0, 4'hf);
    wcase(CLS_16, 32'h100, 16'h10, 16'h10, 1'b0, 4'hf);
    wcase(8'h04, 32'h100, 16'h10, 16'h10, 1'b0, 4'h7);
    wcase(CLS_8, 32'h104, 16'h10, 16'h10, 1'b0, 4'h7);
    wcase(CLS_8, 32'h100, 16'h07, 16'h10, 1'b0, 4'h7);
    wcase(CLS_8, 32'h100, 16'h10, 16'h07, 1'b0, 4'h7);
    wcase(CLS_8, 32'h100, 16'h10, 16'h10, 1'b1, 4'h7);
    wr(ADDR_CFG, 32'h0800_0000);
    wcase(CLS_8, 32'h100, 16'h10, 16'h10, 1'b0, 4'h7);
    burst(1'b0, 32'h100, 8'h0c, 8'hff, TERM_NORMAL);
    chk({24'h0, cnt}, 32'h8);
    wr(ADDR_CFG, 32'h0);
    burst(1'b0, 32'h100, 8'h0c, 8'hff, TERM_NORMAL);
    chk({24'h0, cnt}, 32'hc);
    wr(ADDR_CFG, 32'h0100_0000);
    space_dwords_in <= 16'h4;
    burst(1'b0, 32'h100, 8'h0c, 8'hff, TERM_NORMAL);
    chk({28'h0, cmd_out}, 32'hf);
    chk({24'h0, cnt}, 32'h8);
    wr(ADDR_CFG, 32'h0400_0000);
    rd_ctrl_struct_in <= 1'b1;
    burst(1'b1, 32'h104, 8'h01, 8'hff, TERM_NORMAL);
    chk(start_addr_out, 32'h100);
    {rd_ctrl_struct_in, tx_fifo_nearly_full_in} <= 2'b01;
    burst(1'b1, 32'h100, 8'h0c, 8'hff, TERM_NORMAL);
    chk({24'h0, cnt}, 32'h8);
    {tx_fifo_nearly_full_in, other_dma_pending_in} <= 2'b01;
    wr(ADDR_TX_MAX, 32'h1);
    burst(1'b1, 32'h100, 8'h0c, 8'hff, TERM_NORMAL);
    chk({24'h0, cnt}, 32'h8);
    wr(ADDR_CFG, 32'h0);
    burst(1'b1, 32'h100, 8'h0c, 8'hff, TERM_NORMAL);
    chk({24'h0, cnt}, 32'hc);
    wr(ADDR_PCI_CMD, 32'h40);
    burst(1'b0, 32'h100, 8'h02, 8'h01, TERM_NORMAL);
    rdc(ADDR_PCI_STATUS, 32'h100);
    wr(ADDR_PCI_STATUS, 32'hffff);
    burst(1'b1, 32'h100, 8'h02, 8'h01, TERM_NORMAL);
    rdc(ADDR_PCI_STATUS, 32'h8100);
    wr(ADDR_PCI_STATUS, 32'hffff);
    burst(1'b1, 32'h100, 8'h02, 8'hff, TERM_ABORT);
    rdc(ADDR_PCI_STATUS, 32'h1000);
    burst(1'b1, 32'h100, 8'h02, 8'hff, TERM_RETRY);
    burst(1'b1, 32'h100, 8'h02, 8'hff, TERM_DISCONNECT);
    wr(ADDR_POWER, 32'h1);
    #1 chk({31'h0, start_ok_out}, 32'h0);
    wr(ADDR_POWER, 32'h0);
    #1 chk({31'h0, start_ok_out}, 32'h1);
    stop_test();
  end
endmodule : testbench
bind burst_policy burst_policy_asserts burst_policy_asserts_i (.*);
`default_nettype wire
